//--- include/pp_defs.svh
/*
  Constants of the hit front end: register offsets, field positions, reset values and timing counts.
  Assumes a single 50 MHz system clock and a classic Wishbone register bus with byte addresses.
*/
// Overview of operation
// - Programmable phase delay on crossing sampling.
// - Second delay sets window width, 25-49 ns; the logic opens one crossing plus 0 to 47 clocks.
// - Phase and width shared per board group.
// - Per-channel mask suppresses identified hit output.
// - Hit flagged in one or two crossings; the logic flags up to 25 with the widest window.
// - Trigger gives one pulse, 12-bit width code.
// - Four-bit amplitude setting, values 0 to 15.
// - Polarity select swaps true and complement outputs.
// - Trigger sampled on rising or falling phase.
// - Pulse delay is coarse plus fine delay.
// - Polarity select high inverts every received hit.
// - Route select high bypasses delay and identification.
// - Sixteen positive-logic hit outputs per group.
// - Mask bit zero masks, one enables channel.
// - Edge setting zero rising, one falling.
// - Fine delay codes six bits, 0 to 47.
// - Width code counts whole crossing periods.
`ifndef PP_DEFS_SVH
`define PP_DEFS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define PP_ADDR_W 8
`define PP_GROUP_BIT 5
`define PP_REG_MASK 5'h00
`define PP_REG_HIT_DELAY 5'h04
`define PP_REG_CROSS 5'h08
`define PP_REG_PULSE_CFG 5'h0c
`define PP_REG_PULSE_WIDTH 5'h10
`define PP_REG_STATUS 5'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PP_PHASE_LSB 0
`define PP_WINDOW_LSB 8
`define PP_COARSE_LSB 0
`define PP_FINE_LSB 4
`define PP_EDGE_BIT 12
`define PP_AMP_LSB 16
`define PP_ST_STATE_LSB 0
`define PP_ST_ON_BIT 2
`define PP_ST_DRIVE_BIT 3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PP_MASK_RST 16'hffff
`define PP_HIT_DELAY_RST 6'h2f
`define PP_PHASE_RST 6'h00
`define PP_WINDOW_RST 6'h00
`define PP_COARSE_RST 3'h7
`define PP_FINE_RST 6'h2f
`define PP_EDGE_RST 1'h0
`define PP_AMP_RST 4'h0
`define PP_WIDTH_RST 12'h190
`define PP_CODE_MAX 6'h2f

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PP_CLK_PERIOD_NS 20
`define PP_BX_PERIOD_NS 25
`define PP_BX_CYCLES ((`PP_BX_PERIOD_NS + `PP_CLK_PERIOD_NS - 1) / `PP_CLK_PERIOD_NS)
`define PP_HIST_LEN 96
`define PP_DELAY_DEPTH 64
`define PP_PIN_W 35

`endif

//--- include/pp_pkg.sv
/*
  Types shared by the hit front end: configuration, state records and the pulse sequence states.
  Assumes pp_defs.svh is on the include path.
*/
`include "pp_defs.svh"

package pp_pkg;

  // --------------------------------------------------------------------------
  // Per-group settings
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] mask;
    logic [5:0] hitDelay;
    logic [5:0] phase;
    logic [5:0] window;
    logic [2:0] coarse;
    logic [5:0] fine;
    logic edgeFalling;
    logic [3:0] amplitude;
    logic [11:0] width;
  } grp_cfg_t;

  // Test pulse sequence.
  typedef enum logic [1:0] {PULSE_IDLE, PULSE_COARSE, PULSE_FINE, PULSE_WIDTH} pulse_state_t;

  // --------------------------------------------------------------------------
  // State records
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [`PP_PIN_W-1:0] stage1;
    logic [`PP_PIN_W-1:0] stage2;
  } sync_state_t;

  typedef struct packed {
    logic [`PP_DELAY_DEPTH-1:0][15:0] mem;
    logic [5:0] wrPtr;
    logic [15:0] rdData;
  } delay_state_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [1:0] bxCnt;
    grp_cfg_t [1:0] cfg;
    logic [1:0][15:0][`PP_HIST_LEN-1:0] hist;
    logic [1:0][15:0] hitOut;
    logic [1:0] trigLast;
    pulse_state_t [1:0] pst;
    logic [1:0][13:0] cnt;
    logic [1:0] pulseOn;
    logic [1:0] pulseTrue;
    logic [1:0] driveEn;
  } top_state_t;

endpackage

//--- logic/pin_sync.sv
/*
  Two-stage synchroniser for every pin input of the hit front end.
  Assumes the pins are asynchronous to clk; the first stage feeds only the second.
*/
`timescale 1ns/10ps
`include "pp_defs.svh"

module pin_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic [`PP_PIN_W-1:0] pinIn,
  output logic [`PP_PIN_W-1:0] pinOut
);

  // Registered state and its next value.
  pp_pkg::sync_state_t s;
  pp_pkg::sync_state_t next_s;

  // --------------------------------------------------------------------------
  // Next state: shift the pins through two flip-flops.
  // --------------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.stage1 = pinIn;
    next_s.stage2 = s.stage1;
  end

  // --------------------------------------------------------------------------
  // State register.
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Only the second stage is visible outside.
  assign pinOut = s.stage2;

endmodule

//--- logic/hit_delay_line.sv
/*
  Variable hit delay for one board group: a ring memory of sixteen-bit hit words with registered read.
  Assumes one word is written every clock; delay code is clamped to the valid range by the caller.
*/
`timescale 1ns/10ps
`include "pp_defs.svh"

module hit_delay_line (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] wrData,
  input wire logic [5:0] delay,
  output logic [15:0] rdData
);

  // Registered state and its next value.
  pp_pkg::delay_state_t s;
  pp_pkg::delay_state_t next_s;

  // --------------------------------------------------------------------------
  // Next state: write at the pointer, read the word written delay+1 cycles ago.
  // --------------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.mem[s.wrPtr] = wrData;
    next_s.wrPtr = 6'(s.wrPtr + 6'd1);
    // Total latency is delay + 2 cycles, so code 0 is the shortest path.
    next_s.rdData = s.mem[6'(s.wrPtr - delay - 6'd1)];
  end

  // --------------------------------------------------------------------------
  // State register; reset empties the line so no stale hits emerge.
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdData = s.rdData;

endmodule

//--- logic/hit_front_end.sv
/*
  Hit front end for two sixteen-channel board groups: polarity correction, direct route or
  variable delay plus crossing identification with mask, and a triggered test pulse per group.
  Assumes a classic Wishbone master on clk, asynchronous pins, and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`include "pp_defs.svh"

module hit_front_end (
  input wire logic clk,
  input wire logic reset,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [`PP_ADDR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [15:0] hitInGroupA,
  input wire logic [15:0] hitInGroupB,
  input wire logic inputPolaritySelect,
  input wire logic routeSelect,
  input wire logic pulseTriggerIn,
  output logic [15:0] hitOutGroupA,
  output logic [15:0] hitOutGroupB,
  output logic pulseOutTrueA,
  output logic pulseOutCompA,
  output logic pulseDriveEnA,
  output logic [3:0] pulseAmplitudeA,
  output logic pulseOutTrueB,
  output logic pulseOutCompB,
  output logic pulseDriveEnB,
  output logic [3:0] pulseAmplitudeB
);

  // --------------------------------------------------------------------------
  // Constants
  // --------------------------------------------------------------------------

  // Settings after reset, one copy per group.
  localparam pp_pkg::grp_cfg_t CFG_RST = '{
    mask: `PP_MASK_RST,
    hitDelay: `PP_HIT_DELAY_RST,
    phase: `PP_PHASE_RST,
    window: `PP_WINDOW_RST,
    coarse: `PP_COARSE_RST,
    fine: `PP_FINE_RST,
    edgeFalling: `PP_EDGE_RST,
    amplitude: `PP_AMP_RST,
    width: `PP_WIDTH_RST
  };

  // Last count of the crossing divider and the mid-crossing (falling) phase.
  localparam logic [1:0] BX_LAST = 2'(`PP_BX_CYCLES - 1);
  localparam logic [1:0] BX_HALF = 2'(`PP_BX_CYCLES / 2);
  localparam logic [`PP_HIST_LEN-1:0] HIST_ONES = '1;

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------

  // Codes above the top delay unit are held at the top unit.
  function automatic logic [5:0] clampCode(input logic [5:0] code);
    clampCode = (code > `PP_CODE_MAX) ? `PP_CODE_MAX : code;
  endfunction

  // Window of history taps: starts phase cycles back, one crossing plus gate cycles long.
  function automatic logic [`PP_HIST_LEN-1:0] windowBits(input logic [5:0] phase, input logic [5:0] gate);
    logic [6:0] len;
    len = 7'(`PP_BX_CYCLES) + 7'(clampCode(gate));
    windowBits = (HIST_ONES >> (7'(`PP_HIST_LEN) - len)) << clampCode(phase);
  endfunction

  // Register image of one group; reserved bits read as zero.
  function automatic logic [31:0] regImage(input pp_pkg::grp_cfg_t c, input logic [4:0] off,
                                           input pp_pkg::pulse_state_t st, input logic on, input logic drv);
    regImage = '0;
    case (off)
      `PP_REG_MASK: begin
        regImage[15:0] = c.mask;
      end
      `PP_REG_HIT_DELAY: begin
        regImage[5:0] = c.hitDelay;
      end
      `PP_REG_CROSS: begin
        regImage[`PP_PHASE_LSB +: 6] = c.phase;
        regImage[`PP_WINDOW_LSB +: 6] = c.window;
      end
      `PP_REG_PULSE_CFG: begin
        regImage[`PP_COARSE_LSB +: 3] = c.coarse;
        regImage[`PP_FINE_LSB +: 6] = c.fine;
        regImage[`PP_EDGE_BIT] = c.edgeFalling;
        regImage[`PP_AMP_LSB +: 4] = c.amplitude;
      end
      `PP_REG_PULSE_WIDTH: begin
        regImage[11:0] = c.width;
      end
      `PP_REG_STATUS: begin
        regImage[`PP_ST_STATE_LSB +: 2] = st;
        regImage[`PP_ST_ON_BIT] = on;
        regImage[`PP_ST_DRIVE_BIT] = drv;
      end
      default: begin
        regImage = '0;
      end
    endcase
  endfunction

  // Byte lanes not selected keep their old contents.
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] sel);
    mergeBytes = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        mergeBytes[b*8 +: 8] = wr[b*8 +: 8];
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // State and helpers
  // --------------------------------------------------------------------------
  pp_pkg::top_state_t s; // All registered state.
  pp_pkg::top_state_t next_s; // Next value of the state.
  logic [`PP_PIN_W-1:0] pinSynced; // Pins after two flip-flops.
  logic [1:0][15:0] hitCorr; // Hits after polarity correction.
  logic [1:0][15:0] hitDelayed; // Hits out of the variable delay.
  logic polSynced; // Synchronised polarity select.
  logic routeSynced; // Synchronised route select.
  logic trigSynced; // Synchronised trigger level.

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------

  // All pins cross together; hit pulses shorter than a clock may be missed, which the
  // front-end board's pulse stretching is expected to cover.
  pin_sync pinSync (
    .clk(clk),
    .reset(reset),
    .pinIn({pulseTriggerIn, routeSelect, inputPolaritySelect, hitInGroupB, hitInGroupA}),
    .pinOut(pinSynced)
  );

  assign polSynced = pinSynced[32];
  assign routeSynced = pinSynced[33];
  assign trigSynced = pinSynced[34];

  // Low keeps hit levels as received, high inverts them.
  assign hitCorr[0] = pinSynced[15:0] ^ {16{polSynced}};
  assign hitCorr[1] = pinSynced[31:16] ^ {16{polSynced}};

  // --------------------------------------------------------------------------
  // Variable delay, one line per group
  // --------------------------------------------------------------------------
  hit_delay_line delayA (
    .clk(clk),
    .reset(reset),
    .wrData(hitCorr[0]),
    .delay(clampCode(s.cfg[0].hitDelay)),
    .rdData(hitDelayed[0])
  );

  hit_delay_line delayB (
    .clk(clk),
    .reset(reset),
    .wrData(hitCorr[1]),
    .delay(clampCode(s.cfg[1].hitDelay)),
    .rdData(hitDelayed[1])
  );

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    logic bxStart;
    logic bxHalf;
    logic req;
    logic grp;
    logic [4:0] off;
    logic mapped;
    logic [31:0] merged;
    logic [`PP_HIST_LEN-1:0] win;
    logic [15:0] ident;
    logic trigSample;
    logic trigRise;
    bxStart = 1'b0;
    bxHalf = 1'b0;
    req = 1'b0;
    grp = 1'b0;
    off = '0;
    mapped = 1'b0;
    merged = '0;
    win = '0;
    ident = '0;
    trigSample = 1'b0;
    trigRise = 1'b0;
    next_s = s;

    // Crossing divider: one enable at the crossing start, one at its middle.
    bxStart = (s.bxCnt == 2'd0);
    bxHalf = (s.bxCnt == BX_HALF);
    next_s.bxCnt = (s.bxCnt == BX_LAST) ? 2'd0 : 2'(s.bxCnt + 2'd1);

    // Bus slave. Ack is raised one cycle after the request and dropped the next cycle.
    req = cyc_i & stb_i;
    grp = adr_i[`PP_GROUP_BIT];
    off = adr_i[4:0];
    mapped = (adr_i[`PP_ADDR_W-1:`PP_GROUP_BIT+1] == '0);
    next_s.ack = req & ~s.ack;
    if (req && !s.ack) begin
      // Read data is captured with the ack; unmapped addresses read zero.
      next_s.rdata = mapped ? regImage(s.cfg[grp], off, s.pst[grp], s.pulseOn[grp], s.driveEn[grp]) : 32'h0;
    end
    if (req && s.ack && we_i && mapped) begin
      // The write lands on the edge where the master sees ack.
      merged = mergeBytes(regImage(s.cfg[grp], off, s.pst[grp], s.pulseOn[grp], s.driveEn[grp]), dat_i, sel_i);
      case (off)
        `PP_REG_MASK: begin
          next_s.cfg[grp].mask = merged[15:0];
        end
        `PP_REG_HIT_DELAY: begin
          next_s.cfg[grp].hitDelay = merged[5:0];
        end
        `PP_REG_CROSS: begin
          // One phase and one window setting serve all sixteen channels of the group.
          next_s.cfg[grp].phase = merged[`PP_PHASE_LSB +: 6];
          next_s.cfg[grp].window = merged[`PP_WINDOW_LSB +: 6];
        end
        `PP_REG_PULSE_CFG: begin
          next_s.cfg[grp].coarse = merged[`PP_COARSE_LSB +: 3];
          next_s.cfg[grp].fine = merged[`PP_FINE_LSB +: 6];
          next_s.cfg[grp].edgeFalling = merged[`PP_EDGE_BIT];
          next_s.cfg[grp].amplitude = merged[`PP_AMP_LSB +: 4];
        end
        `PP_REG_PULSE_WIDTH: begin
          next_s.cfg[grp].width = merged[11:0];
        end
        default: begin
          // Status and unmapped offsets ignore writes.
          next_s.cfg[grp] = s.cfg[grp];
        end
      endcase
    end

    // Per-group datapath and test pulse.
    for (int g = 0; g < 2; g++) begin
      // History of delayed hits, newest tap at bit 0.
      for (int ch = 0; ch < 16; ch++) begin
        next_s.hist[g][ch] = {s.hist[g][ch][`PP_HIST_LEN-2:0], hitDelayed[g][ch]};
      end

      // A hit inside the window of a crossing flags that crossing; because the window
      // can exceed one crossing, a hit may flag up to 25 successive crossings.
      win = windowBits(s.cfg[g].phase, s.cfg[g].window);
      for (int ch = 0; ch < 16; ch++) begin
        ident[ch] = |(s.hist[g][ch] & win);
      end
      ident = ident & s.cfg[g].mask;

      if (routeSynced) begin
        // Direct route: corrected levels, no delay and no identification.
        next_s.hitOut[g] = hitCorr[g];
      end else if (bxStart) begin
        // Identified hits stand for one whole crossing.
        next_s.hitOut[g] = ident;
      end

      // Trigger is sampled at the crossing start or at its middle, per the edge setting.
      trigSample = s.cfg[g].edgeFalling ? bxHalf : bxStart;
      if (trigSample) begin
        next_s.trigLast[g] = trigSynced;
      end
      trigRise = trigSample & trigSynced & ~s.trigLast[g];

      case (s.pst[g])
        pp_pkg::PULSE_IDLE: begin
          next_s.pulseOn[g] = 1'b0;
          // A zero amplitude leaves the driver off, so no sequence is started.
          if (trigRise && (s.cfg[g].amplitude != 4'h0)) begin
            next_s.cnt[g] = 14'(s.cfg[g].coarse);
            next_s.pst[g] = pp_pkg::PULSE_COARSE;
          end
        end
        pp_pkg::PULSE_COARSE: begin
          // Coarse delay counts whole crossings; triggers here are ignored.
          if (s.cnt[g] == 14'd0) begin
            next_s.cnt[g] = 14'(clampCode(s.cfg[g].fine));
            next_s.pst[g] = pp_pkg::PULSE_FINE;
          end else if (bxStart) begin
            next_s.cnt[g] = 14'(s.cnt[g] - 14'd1);
          end
        end
        pp_pkg::PULSE_FINE: begin
          // Fine delay counts one clock per delay unit.
          if (s.cnt[g] == 14'd0) begin
            next_s.pulseOn[g] = 1'b1;
            // Width in crossing periods; code zero still gives one period.
            next_s.cnt[g] = (s.cfg[g].width == 12'h0) ? 14'(`PP_BX_CYCLES) :
                            14'(s.cfg[g].width * 14'(`PP_BX_CYCLES));
            next_s.pst[g] = pp_pkg::PULSE_WIDTH;
          end else begin
            next_s.cnt[g] = 14'(s.cnt[g] - 14'd1);
          end
        end
        pp_pkg::PULSE_WIDTH: begin
          // One square pulse; it ends when the width count runs out.
          if (s.cnt[g] <= 14'd1) begin
            next_s.pulseOn[g] = 1'b0;
            next_s.cnt[g] = 14'd0;
            next_s.pst[g] = pp_pkg::PULSE_IDLE;
          end else begin
            next_s.cnt[g] = 14'(s.cnt[g] - 14'd1);
          end
        end
        default: begin
          next_s.pulseOn[g] = 1'b0;
          next_s.pst[g] = pp_pkg::PULSE_IDLE;
        end
      endcase

      // Output levels: polarity low makes the true output positive logic, high swaps them.
      next_s.pulseTrue[g] = next_s.pulseOn[g] ^ polSynced;
      // Driver enable follows the amplitude; software should zero it during data taking
      // because the driver draws a lot of power.
      next_s.driveEn[g] = (next_s.cfg[g].amplitude != 4'h0);
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------

  // Reset aborts any pulse, clears every counter and restores the default settings.
  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
      s.cfg[0] <= CFG_RST;
      s.cfg[1] <= CFG_RST;
    end else begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, all from flip-flops
  // --------------------------------------------------------------------------
  assign dat_o = s.rdata;
  assign ack_o = s.ack;
  assign hitOutGroupA = s.hitOut[0];
  assign hitOutGroupB = s.hitOut[1];

  // Complement is the exact inverse of the true output.
  assign pulseOutTrueA = s.pulseTrue[0];
  assign pulseOutCompA = ~s.pulseTrue[0];
  assign pulseDriveEnA = s.driveEn[0];
  assign pulseAmplitudeA = s.cfg[0].amplitude;
  assign pulseOutTrueB = s.pulseTrue[1];
  assign pulseOutCompB = ~s.pulseTrue[1];
  assign pulseDriveEnB = s.driveEn[1];
  assign pulseAmplitudeB = s.cfg[1].amplitude;

endmodule

//--- tb/hit_front_end_properties.sv
/* Port-level checker for hit_front_end.
   Assumes one clk domain and the synchronous active-high reset. */
`timescale 1ns/10ps
module hit_front_end_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [15:0] hitInGroupA,
  input wire logic inputPolaritySelect,
  input wire logic routeSelect,
  input wire logic [15:0] hitOutGroupA,
  input wire logic pulseOutTrueA,
  input wire logic pulseOutCompA,
  input wire logic pulseDriveEnA,
  input wire logic [3:0] pulseAmplitudeA
);
  // Pins need three edges to reach outputs, so pin history gates the checks.
  logic [2:0] upCnt;
  logic [3:0] routeHist, polHist;
  always_ff @(posedge clk) begin
    upCnt <= reset ? 3'h0 : upCnt + {2'h0, upCnt != 3'h7};
    routeHist <= {routeHist[2:0], routeSelect};
    polHist <= {polHist[2:0], inputPolaritySelect};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("bus request not answered");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  a_direct_route: assert property (upCnt > 3'h4 && routeHist[2] && routeSelect |->
    hitOutGroupA == ($past(hitInGroupA, 3) ^ {16{$past(inputPolaritySelect, 3)}})) else $error("direct hit wrong");
  a_bunch_crossing_identify_steady: assert property (upCnt > 3'h4 && routeHist == 4'h0 && !routeSelect
    && $changed(hitOutGroupA) |=> $stable(hitOutGroupA)) else $error("hit shorter than a crossing");
  a_comp_inverse: assert property (pulseOutCompA == !pulseOutTrueA) else $error("pulse pair not complementary");
  a_drive_amp: assert property (pulseDriveEnA == (pulseAmplitudeA != 4'h0)) else $error("drive enable wrong");
  a_reset_clear: assert property ($fell(reset) |-> !ack_o && hitOutGroupA == 16'h0
    && pulseAmplitudeA == 4'h0 && !pulseOutTrueA) else $error("reset left state");
  a_pulse_amp: assert property (upCnt > 3'h4 && polHist == 4'h0 && $rose(pulseOutTrueA)
    |-> pulseDriveEnA) else $error("pulse without drive");
  c_direct: cover property (routeSelect && hitOutGroupA != 16'h0);
  c_ident: cover property (!routeSelect && $rose(hitOutGroupA[0]));
  c_pulse: cover property ($rose(pulseOutTrueA));
endmodule
bind hit_front_end hit_front_end_properties chk (.clk, .reset, .cyc_i, .stb_i, .ack_o, .hitInGroupA,
  .inputPolaritySelect, .routeSelect, .hitOutGroupA, .pulseOutTrueA, .pulseOutCompA, .pulseDriveEnA,
  .pulseAmplitudeA);

//--- tb/front_end_board_model.sv
/* Stand-in for the front-end board: raw hit levels out, test pulse in.
   Assumes hit requests are positive logic and change once per clk. */
`timescale 1ns/10ps
module front_end_board_model (
  input wire logic clk,
  input wire logic stripBoard,
  input wire logic [15:0] hitA,
  input wire logic [15:0] hitB,
  output logic [15:0] hitInGroupA,
  output logic [15:0] hitInGroupB,
  input wire logic pulseTrue,
  input wire logic pulseComp,
  output logic pulseSeen
);
  // Strip boards send hits active low; the device has to undo it.
  always_ff @(posedge clk) begin
    hitInGroupA <= hitA ^ {16{stripBoard}};
    hitInGroupB <= hitB ^ {16{stripBoard}};
  end
  // The positive leg of the pair depends on the board type.
  assign pulseSeen = stripBoard ? pulseComp : pulseTrue;
endmodule

//--- tb/tb_hit_front_end.sv
/* Self-checking bench: registers, hit routes, masking, identification, test pulse.
   Assumes the board model and the bound checker are compiled alongside. */
`timescale 1ns/10ps
module tb_hit_front_end;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic [3:0] sel_i = 4'hf, pulseAmplitudeA, pulseAmplitudeB;
  logic inputPolaritySelect = 1'b0, routeSelect = 1'b0, pulseTriggerIn = 1'b0, seen;
  logic [15:0] hitA = 16'h0, hitB = 16'h0, hitInGroupA, hitInGroupB, hitOutGroupA, hitOutGroupB;
  logic pulseOutTrueA, pulseOutCompA, pulseDriveEnA, pulseOutTrueB, pulseOutCompB, pulseDriveEnB;
  int err_total = 0, n_checks = 0, c;
  always #10 clk = ~clk;
  front_end_board_model board (.clk, .stripBoard(inputPolaritySelect), .hitA, .hitB, .hitInGroupA,
    .hitInGroupB, .pulseTrue(pulseOutTrueA), .pulseComp(pulseOutCompA), .pulseSeen(seen));
  hit_front_end dut (.clk, .reset, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i, .dat_o, .ack_o,
    .hitInGroupA, .hitInGroupB, .inputPolaritySelect, .routeSelect, .pulseTriggerIn, .hitOutGroupA,
    .hitOutGroupB, .pulseOutTrueA, .pulseOutCompA, .pulseDriveEnA, .pulseAmplitudeA, .pulseOutTrueB,
    .pulseOutCompB, .pulseDriveEnB, .pulseAmplitudeB);
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One classic cycle; the slave's answer time is not assumed, only bounded.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    if (n >= 20) begin
      err_total++;
      report_and_stop();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic count_high(input bit usePulse, input int len);
    c = 0;
    repeat (len) begin
      @(posedge clk);
      c += usePulse ? int'(seen === 1'b1) : int'(hitOutGroupA[0] === 1'b1);
    end
  endtask
  task automatic t_defaults;
    bus(1'b0, 8'h00, 32'h0);
    chk("mask A", q, 32'h0000ffff);
    bus(1'b0, 8'h0c, 32'h0);
    chk("pulse cfg A", q, 32'h000002f7);
    bus(1'b0, 8'h30, 32'h0);
    chk("width B", q, 32'h00000190);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask
  task automatic t_direct;
    routeSelect <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      inputPolaritySelect <= p[0];
      hitA <= 16'ha5c3;
      hitB <= 16'h3c5a;
      repeat (6) @(posedge clk);
      chk("direct A", {16'h0, hitOutGroupA}, 32'ha5c3);
      chk("direct B", {16'h0, hitOutGroupB}, 32'h3c5a);
    end
  endtask
  // Data taking, pulse driver left off: masked A against default B, then windows.
  task automatic t_bunch_crossing_identify;
    routeSelect <= 1'b0;
    inputPolaritySelect <= 1'b0;
    hitA <= 16'hffff;
    hitB <= 16'hffff;
    bus(1'b1, 8'h00, 32'h00ff);
    bus(1'b1, 8'h04, 32'h0);
    repeat (80) @(posedge clk);
    chk("masked A", {16'h0, hitOutGroupA}, 32'h00ff);
    chk("unmasked B", {16'h0, hitOutGroupB}, 32'hffff);
    hitA <= 16'h0;
    hitB <= 16'h0;
    repeat (80) @(posedge clk);
    chk("idle B", {16'h0, hitOutGroupB}, 32'h0);
    for (int w = 0; w < 4; w += 2) begin
      bus(1'b1, 8'h08, w << 8);
      hitA <= 16'h0001;
      @(posedge clk);
      hitA <= 16'h0;
      count_high(1'b0, 60);
      chk("crossings", c, 2 + w);
    end
  endtask
  task automatic pulse_run;
    fork
      begin
        pulseTriggerIn <= 1'b1;
        repeat (4) @(posedge clk);
        pulseTriggerIn <= 1'b0;
        repeat (4) @(posedge clk);
        pulseTriggerIn <= 1'b1;
        repeat (4) @(posedge clk);
        pulseTriggerIn <= 1'b0;
      end
      count_high(1'b1, 120);
    join
  endtask
  task automatic t_pulse;
    bus(1'b1, 8'h10, 32'h14);
    for (int e = 0; e < 2; e++) begin
      inputPolaritySelect <= e[0];
      bus(1'b1, 8'h0c, {12'h0, 4'h0, 3'h0, e[0], 12'h000});
      pulse_run();
      chk("no drive", c, 0);
      bus(1'b1, 8'h0c, {12'h0, 4'h5, 3'h0, e[0], 12'h000});
      pulse_run();
      chk("pulse length", c, 40);
      chk("amplitude", pulseAmplitudeA, 4'h5);
      chk("B pulse", {pulseAmplitudeB, pulseDriveEnB, pulseOutTrueB, pulseOutCompB}, {5'h0, e[0], !e[0]});
    end
    pulseTriggerIn <= 1'b1;
    inputPolaritySelect <= 1'b0;
    repeat (8) @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    pulseTriggerIn <= 1'b0;
    @(posedge clk);
    chk("amp after reset", pulseAmplitudeA, 4'h0);
    count_high(1'b1, 60);
    chk("aborted pulse", c, 0);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_defaults();
    t_direct();
    t_bunch_crossing_identify();
    t_pulse();
    report_and_stop();
  end
endmodule
